// [design/swr_pkg.sv]
// ==========================================================
// link framing constants
package swr_pkg;
   localparam int         ADDR_W     = 6;
   localparam int         DATA_W     = 24;
   localparam logic [7:0] CMD_BYTE   = 8'h01;
   localparam logic [1:0] WR_CODE    = 2'h2;
   localparam logic [1:0] RD_CODE    = 2'h0;
   localparam logic [5:0] CNT_BYTE0  = 6'h07;
   localparam logic [5:0] CNT_BYTE1  = 6'h0F;
   localparam logic [5:0] CNT_BYTE2  = 6'h17;
   localparam logic [5:0] CNT_BYTE3  = 6'h1F;
   localparam logic [5:0] CNT_LAST   = 6'h27;
   localparam logic [5:0] CNT_DATA   = 6'h10;
   localparam logic [5:0] CNT_FRAME  = 6'h28;
   localparam logic [1:0] ISEL_WAIT  = 2'h2;
   localparam int         SCLK_HALF  = 8;
endpackage : swr_pkg

// [design/swr_if.sv]
`timescale 1ns/1ns
// ==========================================================
// serial link between host and device
interface swr_if;
   logic chip_select_n;
   logic chip_select_alt_n;
   logic sclk;
   logic serial_data_in;
   logic serial_data_out_o;
   logic serial_data_out_oe;
   logic serial_data_out;

   // released line reads as pulled high
   assign serial_data_out = serial_data_out_oe ? serial_data_out_o : 1'b1;

   modport dev (
      input  chip_select_n,
      input  chip_select_alt_n,
      input  sclk,
      input  serial_data_in,
      output serial_data_out_o,
      output serial_data_out_oe
   );
   modport host (
      output chip_select_n,
      output chip_select_alt_n,
      output sclk,
      output serial_data_in,
      input  serial_data_out
   );
endinterface : swr_if

// [design/swr_dev.sv]
`timescale 1ns/1ns
module swr_dev
   import swr_pkg::*;
#(
   parameter int DEPTH = 64
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // serial link
   swr_if.dev                     link,
   // straps
   input  wire logic              interface_select_0,
   input  wire logic              interface_select_1,
   // local memory port
   input  wire logic              loc_we,
   input  wire logic [ADDR_W-1:0] loc_addr,
   input  wire logic [DATA_W-1:0] loc_wdata,
   output logic      [DATA_W-1:0] loc_rdata,
   // status
   output logic                   spi_active,
   output logic                   commit_pulse,
   output logic      [ADDR_W-1:0] commit_addr,
   output logic      [DATA_W-1:0] commit_data
);
   // ==========================================================
   // storage
   logic [DATA_W-1:0] mem [DEPTH];

   // ==========================================================
   // synchronisers
   logic [1:0] cs_sy;
   logic [2:0] ck_sy;
   logic [1:0] di_sy;
   logic [1:0] is_sy;
   logic       cs_low;
   logic       rise;
   logic       fall;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cs_sy <= 2'h3;
         ck_sy <= 3'h7;
         di_sy <= 2'h0;
         is_sy <= 2'h3;
      end else begin
         cs_sy <= {cs_sy[0], link.chip_select_n};
         ck_sy <= {ck_sy[1:0], link.sclk};
         di_sy <= {di_sy[0], link.serial_data_in};
         is_sy <= {is_sy[0], interface_select_0};
      end
   end

   assign cs_low = !cs_sy[1];
   assign rise   = ck_sy[1] && !ck_sy[2];
   assign fall   = !ck_sy[1] && ck_sy[2];

   // ==========================================================
   // strap capture
   logic [1:0] isel_cnt;
   logic [1:0] next_isel_cnt;
   logic       next_spi_active;

   always_comb begin
      next_isel_cnt   = isel_cnt;
      next_spi_active = spi_active;
      if (isel_cnt != 2'h3) begin
         next_isel_cnt = isel_cnt + 2'h1;
         if (isel_cnt == ISEL_WAIT) begin
            next_spi_active = !is_sy[1];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         isel_cnt   <= 2'h0;
         spi_active <= 1'b0;
      end else begin
         isel_cnt   <= next_isel_cnt;
         spi_active <= next_spi_active;
      end
   end

   // ==========================================================
   // frame engine
   logic [5:0]        cnt;
   logic [7:0]        sh;
   logic              cmd_ok;
   logic              is_wr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] word;
   logic              so;
   logic              oe;
   logic [5:0]        next_cnt;
   logic [7:0]        next_sh;
   logic              next_cmd_ok;
   logic              next_is_wr;
   logic [ADDR_W-1:0] next_addr;
   logic [DATA_W-1:0] next_word;
   logic              next_so;
   logic              next_oe;
   logic              next_commit;
   logic [5:0]        bit_idx;

   assign bit_idx = CNT_LAST - cnt;

   always_comb begin
      next_cnt    = cnt;
      next_sh     = sh;
      next_cmd_ok = cmd_ok;
      next_is_wr  = is_wr;
      next_addr   = addr;
      next_word   = word;
      next_so     = so;
      next_oe     = oe;
      next_commit = 1'b0;
      if (!cs_low || !spi_active) begin
         // partial frames are dropped here
         next_cnt    = 6'h00;
         next_cmd_ok = 1'b0;
         next_is_wr  = 1'b0;
         next_oe     = 1'b0;
      end else if (rise) begin
         next_sh = {sh[6:0], di_sy[1]};
         if (cnt != CNT_FRAME) begin
            next_cnt = cnt + 6'h01;
         end
         case (cnt)
            CNT_BYTE0: begin
               next_cmd_ok = (next_sh == CMD_BYTE);
            end
            CNT_BYTE1: begin
               next_addr  = next_sh[7:2];
               next_is_wr = (next_sh[1:0] == WR_CODE);
               next_word  = mem[next_sh[7:2]];
            end
            CNT_BYTE2, CNT_BYTE3: begin
               if (is_wr) begin
                  next_word = {word[15:0], next_sh};
               end
            end
            CNT_LAST: begin
               if (is_wr) begin
                  next_word   = {word[15:0], next_sh};
                  next_commit = cmd_ok;
               end
            end
            default: begin
            end
         endcase
      end else if (fall) begin
         if (cmd_ok && !is_wr && cnt >= CNT_DATA && cnt < CNT_FRAME) begin
            next_oe = 1'b1;
            next_so = word[bit_idx[4:0]];
         end else begin
            next_oe = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt    <= 6'h00;
         sh     <= 8'h00;
         cmd_ok <= 1'b0;
         is_wr  <= 1'b0;
         addr   <= '0;
         word   <= '0;
         so     <= 1'b1;
         oe     <= 1'b0;
      end else begin
         cnt    <= next_cnt;
         sh     <= next_sh;
         cmd_ok <= next_cmd_ok;
         is_wr  <= next_is_wr;
         addr   <= next_addr;
         word   <= next_word;
         so     <= next_so;
         oe     <= next_oe;
      end
   end

   assign link.serial_data_out_o  = so;
   assign link.serial_data_out_oe = oe;

   // ==========================================================
   // memory and status
   logic              next_pulse;
   logic [ADDR_W-1:0] next_caddr;
   logic [DATA_W-1:0] next_cdata;

   always_comb begin
      next_pulse = next_commit;
      next_caddr = commit_addr;
      next_cdata = commit_data;
      if (next_commit) begin
         next_caddr = addr;
         next_cdata = next_word;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         commit_pulse <= 1'b0;
         commit_addr  <= '0;
         commit_data  <= '0;
         loc_rdata    <= '0;
      end else begin
         commit_pulse <= next_pulse;
         commit_addr  <= next_caddr;
         commit_data  <= next_cdata;
         loc_rdata    <= mem[loc_addr];
      end
   end

   // link write wins over a local write in the same cycle
   always_ff @(posedge clk) begin
      if (next_commit) begin
         mem[addr] <= next_word;
      end else if (loc_we) begin
         mem[loc_addr] <= loc_wdata;
      end
   end
endmodule : swr_dev

// [design/swr_host.sv]
`timescale 1ns/1ns
module swr_host
   import swr_pkg::*;
#(
   parameter int HALF = SCLK_HALF
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // serial link
   swr_if.host                    link,
   // request
   input  wire logic              start,
   input  wire logic              is_write,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   // answer
   output logic                   busy,
   output logic                   done,
   output logic      [DATA_W-1:0] rdata
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_LEAD = 3'b001,
      H_LOW  = 3'b010,
      H_HIGH = 3'b011,
      H_TAIL = 3'b100,
      H_GAP  = 3'b101
   } swr_hstate_t;

   // ==========================================================
   // miso synchroniser
   logic [1:0] mi_sy;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mi_sy <= 2'h3;
      end else begin
         mi_sy <= {mi_sy[0], link.serial_data_out};
      end
   end

   // ==========================================================
   // sequencer
   swr_hstate_t st;
   swr_hstate_t next_st;
   logic [7:0]  div;
   logic [7:0]  next_div;
   logic [39:0] tx;
   logic [39:0] next_tx;
   logic [39:0] rx;
   logic [39:0] next_rx;
   logic [5:0]  nbit;
   logic [5:0]  next_nbit;
   logic        cs_n;
   logic        next_cs_n;
   logic        sck;
   logic        next_sck;
   logic        mo;
   logic        next_mo;
   logic        next_busy;
   logic        next_done;
   logic [DATA_W-1:0] next_rdata;
   logic        tick;

   assign tick = (div == 8'(HALF - 1));

   always_comb begin
      next_st    = st;
      next_div   = tick ? 8'h00 : div + 8'h01;
      next_tx    = tx;
      next_rx    = rx;
      next_nbit  = nbit;
      next_cs_n  = cs_n;
      next_sck   = sck;
      next_mo    = mo;
      next_busy  = busy;
      next_done  = 1'b0;
      next_rdata = rdata;
      case (st)
         H_IDLE: begin
            next_div = 8'h00;
            if (start) begin
               next_tx   = {CMD_BYTE, addr, is_write ? WR_CODE : RD_CODE,
                            is_write ? wdata : 24'h00_0000};
               next_nbit = 6'h00;
               next_cs_n = 1'b0;
               next_busy = 1'b1;
               next_st   = H_LEAD;
            end
         end
         H_LEAD, H_HIGH: begin
            if (tick) begin
               if (nbit == CNT_FRAME) begin
                  next_st = H_TAIL;
               end else begin
                  next_sck = 1'b0;
                  next_mo  = tx[39];
                  next_tx  = {tx[38:0], 1'b0};
                  next_st  = H_LOW;
               end
            end
         end
         H_LOW: begin
            if (tick) begin
               next_sck  = 1'b1;
               next_rx   = {rx[38:0], mi_sy[1]};
               next_nbit = nbit + 6'h01;
               next_st   = H_HIGH;
            end
         end
         H_TAIL: begin
            if (tick) begin
               next_cs_n  = 1'b1;
               next_done  = 1'b1;
               next_rdata = rx[DATA_W-1:0];
               next_st    = H_GAP;
            end
         end
         H_GAP: begin
            if (tick) begin
               next_busy = 1'b0;
               next_st   = H_IDLE;
            end
         end
         default: begin
            next_st = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st    <= H_IDLE;
         div   <= 8'h00;
         tx    <= '0;
         rx    <= '0;
         nbit  <= 6'h00;
         cs_n  <= 1'b1;
         sck   <= 1'b1;
         mo    <= 1'b0;
         busy  <= 1'b0;
         done  <= 1'b0;
         rdata <= '0;
      end else begin
         st    <= next_st;
         div   <= next_div;
         tx    <= next_tx;
         rx    <= next_rx;
         nbit  <= next_nbit;
         cs_n  <= next_cs_n;
         sck   <= next_sck;
         mo    <= next_mo;
         busy  <= next_busy;
         done  <= next_done;
         rdata <= next_rdata;
      end
   end

   assign link.chip_select_n     = cs_n;
   assign link.chip_select_alt_n = 1'b1;
   assign link.sclk              = sck;
   assign link.serial_data_in    = mo;
endmodule : swr_host

// [tb/swr_asserts.sv]
`timescale 1ns/1ns
// ==========================================================
// link checker
module swr_asserts
   import swr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // link
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic serial_data_in,
   input wire logic serial_data_out_o,
   input wire logic serial_data_out_oe
);
   logic        sq;
   logic        next_sq;
   logic [5:0]  n;
   logic [5:0]  next_n;
   logic [15:0] hd;
   logic [15:0] next_hd;
   logic        rd;

   // ==========================================================
   // bit count and command capture
   assign rd = (hd[15:8] == CMD_BYTE) && (hd[1:0] != WR_CODE);
   always_comb begin
      next_sq = sclk;
      next_n  = n;
      next_hd = hd;
      if (chip_select_n) begin
         next_n = 6'h00;
      end else if (sclk && !sq) begin
         next_n = n + 6'h01;
         if (n < CNT_DATA) begin
            next_hd = {hd[14:0], serial_data_in};
         end
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sq <= 1'b1;
         n  <= 6'h00;
         hd <= 16'h0000;
      end else begin
         sq <= next_sq;
         n  <= next_n;
         hd <= next_hd;
      end
   end

   // ==========================================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_release;
      ##[1:6] !serial_data_out_oe;
   endsequence
   sequence s_high_held;
      sclk && $past(sclk, 4) && !chip_select_n;
   endsequence

   a_clk_idle_high: assert property (chip_select_n |-> sclk)
      else $error("clock low while deselected");
   a_out_steady: assert property (s_high_held |-> $stable(serial_data_out_o))
      else $error("output changed while clock high");
   a_in_steady: assert property (sclk && $past(sclk) && !chip_select_n && !$past(chip_select_n)
      |-> $stable(serial_data_in))
      else $error("input changed while clock high");
   a_cmd_quiet: assert property (!chip_select_n && n < CNT_DATA |-> !serial_data_out_oe)
      else $error("output driven during command bytes");
   a_write_quiet: assert property (n >= CNT_DATA && !rd |-> !serial_data_out_oe)
      else $error("output driven during write");
   a_read_drives: assert property (!chip_select_n && n > CNT_DATA && rd |-> serial_data_out_oe)
      else $error("output not driven during read data");
   a_frame_bits: assert property ($rose(chip_select_n) |-> $past(n) == CNT_FRAME)
      else $error("frame length not forty bits");
   a_oe_release: assert property ($rose(chip_select_n) |-> s_release)
      else $error("output not released after frame");
endmodule : swr_asserts

// [tb/test_spi_word_ram_access_slave.sv]
`timescale 1ns/1ns
// ==========================================================
// bench
module test_spi_word_ram_access_slave
   import swr_pkg::*;
;
   logic        clk, rst_b, start, is_write, busy, done, loc_we, act, cpl, sel_x, act_x, cpl_x, sel1;
   logic        sel0;
   logic [5:0]  addr, loc_addr, caddr, caddr_x, a;
   logic [23:0] wdata, rdata, loc_wdata, loc_rdata, cdata, cdata_x, d, mm [64];
   logic [29:0] qc [$];
   logic [23:0] qr [$];
   int          fail_count, checks_done;
   int unsigned rs;

   swr_if swr_if_i ();
   swr_if swr_if_x_i ();
   swr_host #(.HALF(8)) swr_host_i (.clk(clk), .rst_b(rst_b), .link(swr_if_i), .start(start),
      .is_write(is_write), .addr(addr), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
   swr_dev swr_dev_i (.clk(clk), .rst_b(rst_b), .link(swr_if_i), .interface_select_0(sel0),
      .interface_select_1(sel1), .loc_we(loc_we), .loc_addr(loc_addr), .loc_wdata(loc_wdata),
      .loc_rdata(loc_rdata), .spi_active(act), .commit_pulse(cpl), .commit_addr(caddr),
      .commit_data(cdata));
   swr_dev swr_dev_x_i (.clk(clk), .rst_b(rst_b), .link(swr_if_x_i), .interface_select_0(sel_x),
      .interface_select_1(sel1), .loc_we(1'b0), .loc_addr(loc_addr), .loc_wdata(loc_wdata),
      .loc_rdata(), .spi_active(act_x), .commit_pulse(cpl_x), .commit_addr(caddr_x),
      .commit_data(cdata_x));
   swr_asserts swr_asserts_i (.clk(clk), .rst_b(rst_b), .chip_select_n(swr_if_i.chip_select_n),
      .sclk(swr_if_i.sclk), .serial_data_in(swr_if_i.serial_data_in),
      .serial_data_out_o(swr_if_i.serial_data_out_o),
      .serial_data_out_oe(swr_if_i.serial_data_out_oe));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ==========================================================
   // compare and close
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   always @(negedge clk) begin
      if (done === 1'b1) begin
         if (qr.size() == 0) chk(1, 0);
         else chk(rdata, qr.pop_front());
      end
      if (cpl === 1'b1 || cpl_x === 1'b1) begin
         if (qc.size() == 0) chk(1, 0);
         else chk(cpl ? {caddr, cdata} : {caddr_x, cdata_x}, qc.pop_front());
      end
   end

   // ==========================================================
   // drivers
   task automatic hop(input logic w, input logic [5:0] ad, input logic [23:0] dt);
      int k;
      @(negedge clk);
      start = 1'b1;
      is_write = w;
      addr = ad;
      wdata = dt;
      if (w) begin
         qr.push_back(24'hFF_FFFF);
         qc.push_back({ad, dt});
         mm[ad] = dt;
      end else qr.push_back(mm[ad]);
      @(negedge clk);
      start = 1'b0;
      k = 0;
      @(negedge clk);
      while (busy !== 1'b0 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      if (k == 2000) begin
         fail_count++;
         wrap_up();
      end
   endtask : hop

   task automatic lw(input logic [5:0] ad, input logic [23:0] dt);
      @(negedge clk);
      loc_we = 1'b1;
      loc_addr = ad;
      loc_wdata = dt;
      mm[ad] = dt;
      @(negedge clk);
      loc_we = 1'b0;
   endtask : lw

   task automatic lchk(input logic [5:0] ad);
      @(negedge clk);
      loc_addr = ad;
      repeat (2) @(negedge clk);
      chk(loc_rdata, mm[ad]);
   endtask : lchk

   task automatic xf(input logic [39:0] v, input int nb, input int pz, input logic [39:0] exp);
      logic [39:0] got;
      got = '0;
      swr_if_x_i.chip_select_n = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < nb; i++) begin
         swr_if_x_i.sclk = 1'b0;
         swr_if_x_i.serial_data_in = v[39-i];
         repeat (4) @(negedge clk);
         got = {got[38:0], swr_if_x_i.serial_data_out};
         swr_if_x_i.sclk = 1'b1;
         repeat (4) @(negedge clk);
         if (i == pz) repeat (75) @(negedge clk);
      end
      swr_if_x_i.chip_select_n = 1'b1;
      swr_if_x_i.serial_data_in = ~swr_if_x_i.serial_data_in;
      repeat (16) @(negedge clk);
      if (nb == 40) chk(got, exp);
   endtask : xf

   // ==========================================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      {start, is_write, addr, wdata, loc_we, loc_addr, loc_wdata} = '0;
      sel_x = 1'b1;
      sel0 = 1'b0;
      fail_count = 0;
      checks_done = 0;
      swr_if_x_i.chip_select_n = 1'b1;
      swr_if_x_i.chip_select_alt_n = 1'b1;
      swr_if_x_i.sclk = 1'b1;
      swr_if_x_i.serial_data_in = 1'b0;
      rs = $urandom(27);
      sel1 = 1'($urandom());
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      chk({act, act_x}, 2'b10);
      xf({CMD_BYTE, 6'h05, WR_CODE, 24'h12_3456}, 40, -1, '1);
      rst_b = 1'b0;
      sel_x = 1'b0;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      chk({act, act_x}, 2'b11);
      sel0 = 1'b1;
      sel_x = 1'b1;
      foreach (mm[i]) lw(6'(i), 24'($urandom()));
      for (int i = 0; i < 6; i++) hop(1'b0, (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom()),
         24'h00_0000);
      for (int i = 0; i < 4; i++) begin
         a = 6'($urandom());
         hop(1'b1, a, 24'($urandom()));
         hop(1'b0, a, 24'h00_0000);
         lchk(a);
      end
      a = 6'h2A;
      d = 24'($urandom());
      xf({CMD_BYTE, a, WR_CODE, d}, 30, -1, '1);
      qc.push_back({a, d});
      xf({CMD_BYTE, a, WR_CODE, d}, 40, 20, '1);
      xf({CMD_BYTE, a, 2'b11, 24'h00_0000}, 40, 30, {16'hFFFF, d});
      xf({8'h02, a, WR_CODE, ~d}, 40, -1, '1);
      xf({CMD_BYTE, a, RD_CODE, 24'h00_0000}, 40, -1, {16'hFFFF, d});
      repeat (20) @(negedge clk);
      chk(qc.size() + qr.size(), 0);
      wrap_up();
   end
endmodule : test_spi_word_ram_access_slave
